// File: logic/mdu_upconverter_top.sv
/*
 mdu_upconverter_top.sv - four interpolating up-converter channels, mask-based routing and
 summing onto two converter outputs, and a final dual-edge 2x stage.
 Assumes: one clock mclk; register port and sample port driven by logic on mclk; the link
 side presents a sample set whenever in_take is high.
*/
`timescale 1ns/1ps

`include "mdu_consts.svh"

// ----------------------------------------
// one zero-stuffing interpolation stage
// ----------------------------------------
module mdu_interp_stage #(
	parameter int N  = 11,
	parameter int SH = 8
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               in_stb,
	input  wire logic               out_stb,
	input  wire mdu_pkg::mdu_smp_t  din,
	input  wire mdu_pkg::mdu_coef_t coef [N],
	output mdu_pkg::mdu_smp_t       dout
);
	import mdu_pkg::*;

	mdu_smp_t           line_ff [N];
	logic signed [47:0] acc;

	// delay line at output rate, zeros between input samples
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < N; i++)
				line_ff[i] <= '0;
		end
		else if (out_stb)
		begin
			line_ff[0] <= in_stb ? din : '0;
			for (int i = 1; i < N; i++)
				line_ff[i] <= line_ff[i-1];
		end
	end

	// symmetric fir sum, full precision
	always_comb
	begin
		acc = '0;
		for (int i = 0; i < N; i++)
			acc = acc + 48'(coef[i]) * 48'(line_ff[i]);
	end

	// scaled and clamped result, held between output strobes
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			dout <= '0;
		else if (out_stb)
			dout <= sat16(acc >>> SH);
	end
endmodule : mdu_interp_stage

// ----------------------------------------
// top: registers, channels, routing
// ----------------------------------------
module mdu_upconverter_top (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire mdu_pkg::mdu_bus_t  bus,
	output logic [31:0]             rdata,
	input  wire mdu_pkg::mdu_in_t   in_data,
	output logic                    in_take,
	output mdu_pkg::mdu_pair_t      out_a,
	output mdu_pkg::mdu_pair_t      out_b
);
	import mdu_pkg::*;

	localparam mdu_coef_t HALF [126] = `MDU_COEF_HALVES;
	localparam mdu_smp_t  SINQ [17]  = `MDU_SINE_QUARTER;

	logic [31:0]        cfg_ff;
	logic [31:0]        outcfg_ff;
	logic [31:0]        freq_ff [4];
	logic [31:0]        rdata_ff;
	logic [31:0]        rd_mux;
	logic [1:0]         sat_ff;
	logic [1:0]         sat_clr;
	wire  [1:0]         sat_ev;
	logic               restart;
	logic [3:0]         code;
	logic               cplx;
	logic [3:0]         osc_en;
	logic [3:0]         nst;
	logic               first3x;
	logic [8:0]         per [9];
	logic [8:0]         cnt_ff [9];
	logic [8:0]         stb_ff;
	mdu_smp_t           raw_ff [4];
	wire  mdu_smp_t     chan [4][2];
	wire  mdu_smp_t     mix_re [4];
	wire  mdu_smp_t     mix_im [4];
	mdu_smp_t           src [4];

	// sine from a 6-bit phase using quarter-wave symmetry
	function automatic mdu_smp_t sin64(input logic [5:0] p);
		mdu_smp_t m;
		m = p[4] ? SINQ[5'h10 - 5'(p[3:0])] : SINQ[p[3:0]];
		return p[5] ? -m : m;
	endfunction : sin64

	// ----------------------------------------
	// register port
	// ----------------------------------------
	assign restart = bus.wr && bus.addr == `MDU_OFS_CFG;
	assign sat_clr = (bus.wr && bus.addr == `MDU_OFS_STAT) ? bus.wdata[`MDU_STAT_SAT] : 2'h0;

	// software writes
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ff    <= `MDU_RST_CFG;
			outcfg_ff <= `MDU_RST_OUT;
			for (int k = 0; k < 4; k++)
				freq_ff[k] <= `MDU_RST_FREQ;
		end
		else if (bus.wr)
		begin
			if (bus.addr == `MDU_OFS_CFG)
				cfg_ff <= bus.wdata;
			if (bus.addr == `MDU_OFS_OUT)
				outcfg_ff <= bus.wdata;
			for (int k = 0; k < 4; k++)
				if (bus.addr == 5'(`MDU_OFS_FREQ0 + 4 * k))
					freq_ff[k] <= bus.wdata;
		end
	end

	// sticky saturation flags, a new event beats the clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sat_ff <= 2'h0;
		else
			sat_ff <= sat_ev | (sat_ff & ~sat_clr);
	end

	// read decode, unmapped addresses read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (bus.addr == `MDU_OFS_CFG)
			rd_mux = cfg_ff;
		if (bus.addr == `MDU_OFS_OUT)
			rd_mux = outcfg_ff;
		for (int k = 0; k < 4; k++)
			if (bus.addr == 5'(`MDU_OFS_FREQ0 + 4 * k))
				rd_mux = freq_ff[k];
		if (bus.addr == `MDU_OFS_STAT)
		begin
			rd_mux[`MDU_STAT_SAT] = sat_ff;
			rd_mux[`MDU_STAT_NST] = nst;
		end
	end

	// read data stands for the one cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0000_0000;
		else
			rdata_ff <= bus.rd ? rd_mux : 32'h0000_0000;
	end
	assign rdata = rdata_ff;

	// ----------------------------------------
	// rate plan
	// ----------------------------------------
	assign code    = cfg_ff[`MDU_CFG_INTERP];
	assign cplx    = cfg_ff[`MDU_CFG_CPLX];
	assign osc_en  = cfg_ff[`MDU_CFG_OSC];
	assign nst     = 4'((5'(code) + 5'h01) >> 1);
	assign first3x = code != 4'h0 && !code[0];

	// strobe periods, input side at index 0, converter side at index 8
	always_comb
	begin
		per[8] = 9'h001;
		for (int s = 7; s >= 0; s--)
			if (4'(s) >= nst)
				per[s] = per[s+1];
			else if (s == 0 && first3x)
				per[s] = 9'(per[s+1] * 9'h003);
			else
				per[s] = 9'(per[s+1] << 1);
	end

	// one divider per rate, all restarted together on a config write
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stb_ff <= 9'h000;
			for (int s = 0; s < 9; s++)
				cnt_ff[s] <= 9'h000;
		end
		else
		begin
			for (int s = 0; s < 9; s++)
			begin
				stb_ff[s] <= cnt_ff[s] == 9'h000;
				if (restart)
					cnt_ff[s] <= 9'h000;
				else if (cnt_ff[s] == 9'h000)
					cnt_ff[s] <= 9'(per[s] - 9'h001);
				else
					cnt_ff[s] <= 9'(cnt_ff[s] - 9'h001);
			end
		end
	end
	assign in_take = stb_ff[0];

	// raw input streams for the no-interpolation modes
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < 4; k++)
				raw_ff[k] <= '0;
		end
		else if (stb_ff[0])
		begin
			for (int k = 0; k < 4; k++)
				raw_ff[k] <= in_data.strm[k];
		end
	end

	// ----------------------------------------
	// up-converter channels
	// ----------------------------------------
	for (genvar k = 0; k < 4; k++)
	begin : g_ch
		logic [31:0] ph_ff;
		mdu_smp_t    sn;
		mdu_smp_t    cs;
		mdu_smp_t    re_ff;
		mdu_smp_t    im_ff;

		for (genvar c = 0; c < 2; c++)
		begin : g_iq
			wire mdu_smp_t d [9];
			assign d[0] = in_data.strm[2*k+c];
			for (genvar s = 0; s < 8; s++)
			begin : g_slot
				localparam int N  = (s == 0) ? 95 : (s == 1) ? 23 : 11;
				localparam int SH = (s == 0) ? 19 : (s == 1) ? 14 : (s == 2) ? 11 : 8;
				mdu_coef_t  cf [N];
				mdu_smp_t   o;
				logic [6:0] base;

				// pick the filter that this position holds for the factor
				always_comb
				begin
					if (s == 0)
						base = first3x ? `MDU_H_FIR3X : `MDU_H_FIR1;
					else if (s == 1)
						base = `MDU_H_FIR2;
					else if (s == 2)
						base = `MDU_H_FIR3;
					else if (s == 3 || 4'(s) + 4'h2 < nst)
						base = `MDU_H_FIR4;
					else
						base = `MDU_H_FIR5;
					for (int i = 0; i < N; i++)
						cf[i] = HALF[base + 7'((i < (N + 1) / 2) ? i : N - 1 - i)];
				end

				mdu_interp_stage #(.N(N), .SH(SH)) u_stage (
					.mclk    (mclk),
					.rst_n   (rst_n),
					.in_stb  (stb_ff[s]),
					.out_stb (stb_ff[s+1]),
					.din     (d[s]),
					.coef    (cf),
					.dout    (o)
				);
				assign d[s+1] = (4'(s) < nst) ? o : d[s];
			end
			assign chan[k][c] = d[8];
		end

		// oscillator phase, held at zero while bypassed
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
				ph_ff <= 32'h0000_0000;
			else
				ph_ff <= osc_en[k] ? ph_ff + freq_ff[k] : 32'h0000_0000;
		end
		assign sn = sin64(ph_ff[31:26]);
		assign cs = sin64(6'(ph_ff[31:26] + 6'h10));

		// complex mix or straight pass
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				re_ff <= '0;
				im_ff <= '0;
			end
			else if (osc_en[k])
			begin
				re_ff <= sat16((48'(chan[k][0]) * 48'(cs) - 48'(chan[k][1]) * 48'(sn)) >>> 15);
				im_ff <= sat16((48'(chan[k][0]) * 48'(sn) + 48'(chan[k][1]) * 48'(cs)) >>> 15);
			end
			else
			begin
				re_ff <= chan[k][0];
				im_ff <= chan[k][1];
			end
		end
		assign mix_re[k] = re_ff;
		assign mix_im[k] = im_ff;
	end

	// ----------------------------------------
	// routing and converter outputs
	// ----------------------------------------
	// source words behind the four mask bits
	always_comb
	begin
		for (int k = 0; k < 4; k++)
			if (code == 4'h0)
				src[k] = raw_ff[k];
			else if (!cplx || k < 2)
				src[k] = mix_re[k];
			else
				src[k] = mix_im[k-2];
	end

	for (genvar o = 0; o < 2; o++)
	begin : g_out
		logic [3:0]         mask;
		mdu_mode_t          mode;
		logic signed [17:0] sum;
		logic signed [23:0] hb;
		mdu_smp_t           sum_sat;
		mdu_smp_t           h_ff [4];
		mdu_pair_t          pair_ff;

		assign mask = (o == 0) ? outcfg_ff[`MDU_OUT_SRC_A] : outcfg_ff[`MDU_OUT_SRC_B];
		assign mode = mdu_mode_t'((o == 0) ? outcfg_ff[`MDU_OUT_MODE_A] : outcfg_ff[`MDU_OUT_MODE_B]);

		// masked sum of the selected sources
		always_comb
		begin
			sum = '0;
			for (int k = 0; k < 4; k++)
				if (mask[k])
					sum = sum + 18'(src[k]);
		end
		assign sum_sat   = sat16(48'(sum));
		assign sat_ev[o] = sum != 18'(sum_sat);
		assign hb = 24'(h_ff[1]) * 24'sh000009 + 24'(h_ff[2]) * 24'sh000009 - 24'(h_ff[0]) - 24'(h_ff[3]);

		// short history for the final half-band
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				for (int i = 0; i < 4; i++)
					h_ff[i] <= '0;
			end
			else
			begin
				h_ff[0] <= sum_sat;
				for (int i = 1; i < 4; i++)
					h_ff[i] <= h_ff[i-1];
			end
		end

		// sample pair per mode
		always_ff @(posedge mclk or negedge rst_n)
		begin
			if (!rst_n)
				pair_ff <= '0;
			else
			begin
				unique case (mode)
					mdu_mode_nrz, mdu_mode_rtz, mdu_mode_rf:
						pair_ff <= '{odd: sum_sat, even: sum_sat};
					mdu_mode_dual_edge_no_interp:
						pair_ff <= '{odd: raw_ff[1], even: raw_ff[0]};
					mdu_mode_dual_edge_interp:
						pair_ff <= '{odd: sat16(48'(hb) >>> 4), even: h_ff[2]};
					default:
						pair_ff <= '0;
				endcase
			end
		end
	end

	assign out_a = g_out[0].pair_ff;
	assign out_b = g_out[1].pair_ff;
endmodule : mdu_upconverter_top

// File: logic/mdu_consts.svh
/*
 mdu_consts.svh - register offsets, field positions, reset values and fixed filter tables
 of the multi-channel up-converter.
 Assumes: included by the up-converter top file by its bare name; holds definitions only.
*/
`ifndef MDU_CONSTS_SVH
`define MDU_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MDU_OFS_CFG     5'h00
`define MDU_OFS_OUT     5'h04
`define MDU_OFS_FREQ0   5'h08
`define MDU_OFS_STAT    5'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define MDU_CFG_INTERP  3:0
`define MDU_CFG_CPLX    4
`define MDU_CFG_OSC     11:8
`define MDU_OUT_SRC_A   3:0
`define MDU_OUT_SRC_B   7:4
`define MDU_OUT_MODE_A  10:8
`define MDU_OUT_MODE_B  14:12
`define MDU_STAT_SAT    1:0
`define MDU_STAT_NST    11:8

// ----------------------------------------
// reset values
// ----------------------------------------
`define MDU_RST_CFG     32'h0000_0000
`define MDU_RST_OUT     32'h0000_0101
`define MDU_RST_FREQ    32'h0000_0000

// ----------------------------------------
// coefficient half tables (first half plus centre) and their bases
// ----------------------------------------
`define MDU_H_FIR1      7'h00
`define MDU_H_FIR3X     7'h30
`define MDU_H_FIR2      7'h60
`define MDU_H_FIR3      7'h6C
`define MDU_H_FIR4      7'h72
`define MDU_H_FIR5      7'h78
`define MDU_COEF_HALVES '{0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0, \
	48,0,-152,0,376,0,-800,0,1536,0,-2736,0,4576,0,-7312,0,11272,0,-16952,0,25216,0,-37832,0, \
	59360,0,-106672,0,332216,524288, \
	-38,-38,0,83,117,0,-214,-281,0,464,584,0,-900,-1102,0,1612,1929,0,-2713,-3190,0,4346,5040,0, \
	-6699,-7684,0,10023,11408,0,-14701,-16661,0,21389,24260,0,-31417,-35960,0,48101,56540,0, \
	-82781,-105224,0,215190,432780,524288, \
	-12,0,84,0,-336,0,1006,0,-2691,0,10141,16384, \
	29,0,-214,0,1209,2048, \
	3,0,-25,0,150,256, \
	0,0,-16,0,144,256}

// quarter-wave sine, 16 steps plus the peak
`define MDU_SINE_QUARTER '{0,3212,6393,9512,12539,15446,18204,20787,23170,25330,27245,28898, \
	30273,31356,32137,32609,32767}

`endif

// File: logic/mdu_pkg.sv
/*
 mdu_pkg.sv - types and the saturation helper shared by the up-converter files.
 Assumes: compiled before every file that imports it.
*/
package mdu_pkg;

	typedef logic signed [15:0] mdu_smp_t;
	typedef logic signed [23:0] mdu_coef_t;

	// register port request, one strobe per cycle
	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} mdu_bus_t;

	// eight real streams: stream 2k is I, 2k+1 is Q of channel k
	typedef struct packed {
		mdu_smp_t [7:0] strm;
	} mdu_in_t;

	// two samples per clock for the dual-edge converter
	typedef struct packed {
		mdu_smp_t odd;
		mdu_smp_t even;
	} mdu_pair_t;

	typedef enum logic [2:0] {
		mdu_mode_off,
		mdu_mode_nrz,
		mdu_mode_rtz,
		mdu_mode_rf,
		mdu_mode_dual_edge_no_interp,
		mdu_mode_dual_edge_interp
	} mdu_mode_t;

	// clamp a wide signed value to the 16-bit sample range
	function automatic mdu_smp_t sat16(input logic signed [47:0] v);
		if (v > 48'sh0000_0000_7FFF)
			return 16'sh7FFF;
		if (v < -48'sh0000_0000_8000)
			return 16'sh8000;
		return v[15:0];
	endfunction : sat16

endpackage : mdu_pkg

// File: testbench/mdu_upconverter_sva.sv
/*
 mdu_upconverter_sva.sv - port checker of the up-converter top.
 Assumes: bound to mdu_upconverter_top; one clock, async low reset.
*/
`timescale 1ns/1ps

// ----------
// checker
// ----------
module mdu_upconverter_sva (
	input wire logic               mclk,
	input wire logic               rst_n,
	input wire mdu_pkg::mdu_bus_t  bus,
	input wire logic [31:0]        rdata,
	input wire mdu_pkg::mdu_in_t   in_data,
	input wire logic               in_take,
	input wire mdu_pkg::mdu_pair_t out_a,
	input wire mdu_pkg::mdu_pair_t out_b
);
	import mdu_pkg::*;
	localparam int FAC [16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
	logic [31:0] cfg_ff;
	logic [31:0] out_ff;
	logic [8:0]  quiet_ff;
	logic [9:0]  gap_ff;
	logic [1:0]  takes_ff;
	logic        cfg_wr;
	logic        out_wr;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// writes to the config and output registers
	assign cfg_wr = bus.wr && bus.addr == 5'h00;
	assign out_wr = bus.wr && bus.addr == 5'h04;

	// shadow copies of both registers
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			cfg_ff <= 32'h0;
			out_ff <= 32'h0000_0101;
		end
		else
		begin
			if (cfg_wr) cfg_ff <= bus.wdata;
			if (out_wr) out_ff <= bus.wdata;
		end

	// settle time, take gap, takes since a config write
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			quiet_ff <= '0;
			gap_ff   <= '0;
			takes_ff <= '0;
		end
		else
		begin
			quiet_ff <= (cfg_wr || out_wr) ? 9'h0 : quiet_ff + {8'h0, quiet_ff != 9'h1FF};
			gap_ff   <= in_take ? 10'h1 : gap_ff + {9'h0, gap_ff != 10'h3FF};
			takes_ff <= cfg_wr ? 2'h0 : takes_ff + {1'b0, in_take && takes_ff != 2'h3};
		end

	AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("rdata not idle");
	AST_READ_OUT: assert property (bus.rd && bus.addr == 5'h04 |=> (rdata & 32'h77FF) == ($past(out_ff) & 32'h77FF))
		else $error("output register readback wrong");
	AST_UNMAPPED: assert property (bus.rd && bus.addr == 5'h1C |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_OFF_A: assert property (quiet_ff > 9'h3F && !(out_ff[10:8] inside {[3'h1:3'h5]}) |-> out_a == 32'h0)
		else $error("disabled output A not silent");
	AST_SAME: assert property (quiet_ff > 9'h3F && out_ff[3:0] == out_ff[7:4] && out_ff[10:8] == out_ff[14:12]
		|-> out_a == out_b)
		else $error("alike outputs differ");
	AST_PAIR_EQ: assert property (quiet_ff > 9'h3F && out_ff[10:8] inside {3'h1, 3'h2, 3'h3}
		|-> out_a.odd == out_a.even)
		else $error("pair differs outside dual-edge");
	AST_TAKE_1X: assert property (quiet_ff > 9'h3 && cfg_ff[3:0] == 4'h0 |-> in_take)
		else $error("take missing at 1x");
	AST_TAKE_GAP: assert property (in_take && takes_ff[1] |-> gap_ff == 10'(FAC[cfg_ff[3:0]]))
		else $error("take period wrong");

	cover property (quiet_ff > 9'h3F && out_ff[10:8] == 3'h4);
	cover property (in_take && takes_ff[1] && cfg_ff[3:0] == 4'hF);
	cover property (bus.rd && bus.addr == 5'h1C);
endmodule : mdu_upconverter_sva

bind mdu_upconverter_top mdu_upconverter_sva chk_u (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
	.in_data(in_data), .in_take(in_take), .out_a(out_a), .out_b(out_b));

// File: testbench/mdu_link_model.sv
/*
 mdu_link_model.sv - link transmitter model feeding the sample port.
 Assumes: the bench supplies the next set; the take pulse paces it.
*/
`timescale 1ns/1ps

// ----------
// link model
// ----------
module mdu_link_model (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_take,
	input  wire mdu_pkg::mdu_in_t next_set,
	output mdu_pkg::mdu_in_t      in_data
);
	import mdu_pkg::*;

	// one full set per take, held until taken
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			in_data <= '0;
		else if (in_take)
			in_data <= next_set;
endmodule : mdu_link_model

// File: testbench/mdu_upconverter_top_tb.sv
/*
 mdu_upconverter_top_tb.sv - self-checking bench of the up-converter top.
 Assumes: package, design, link model and checker compiled first.
*/
`timescale 1ns/1ps

// ----------
// bench
// ----------
module mdu_upconverter_top_tb;
	import mdu_pkg::*;
	int          fac [16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	mdu_bus_t    bus = '0;
	mdu_in_t     tx_set = '0;
	mdu_in_t     in_data;
	logic        in_take;
	logic [31:0] rdata;
	mdu_pair_t   out_a;
	mdu_pair_t   out_b;
	logic [3:0]  m;
	int          v [8];
	int          n;
	int          seed = 32'h22a38f01;
	int          miscompares = 0;
	int          tests_run = 0;

	always #2.5 mclk = ~mclk;

	mdu_upconverter_top dut_u (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .in_data(in_data),
		.in_take(in_take), .out_a(out_a), .out_b(out_b));
	mdu_link_model link_u (.mclk(mclk), .rst_n(rst_n), .in_take(in_take), .next_set(tx_set), .in_data(in_data));

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	// one-cycle register write
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask : wr

	// one-cycle read, data in the following cycle
	task automatic rd(input logic [4:0] a, input logic [31:0] msk, input logic [31:0] exp);
		@(posedge mclk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1;
		chk(rdata & msk, exp);
	endtask : rd

	// saturated sum of streams picked by a 1x mask
	function automatic logic [15:0] msum(input logic [3:0] k_m);
		int s = 0;
		for (int k = 0; k < 4; k++)
			if (k_m[k])
				s += v[k];
		return (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : 16'(s);
	endfunction : msum

	// expected converter pair for a mode and a sum
	function automatic logic [31:0] pair_exp(input int md, input logic [15:0] s);
		case (md)
			1, 2, 3, 5: return {s, s};
			4: return {16'(v[1]), 16'(v[0])};
			default: return 32'h0;
		endcase
	endfunction : pair_exp

	// new stream values, then time to settle
	task automatic feed(input logic big);
		for (int k = 0; k < 8; k++)
		begin
			v[k] = big ? 32767 : int'($signed(16'($random(seed))));
			tx_set.strm[k] <= 16'(v[k]);
		end
		repeat (70) @(posedge mclk);
		#1;
	endtask : feed

	// cycles between one take and the next, neither take counted
	task automatic meas(output int cnt);
		cnt = 0;
		@(posedge mclk);
		#1;
		while (in_take !== 1'b1 && cnt < 600)
		begin
			cnt++;
			@(posedge mclk);
			#1;
		end
	endtask : meas

	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// watchdog
	initial
	begin
		repeat (30000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end

	// main sequence
	initial
	begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rd(5'h00, 32'h0000_0F1F, 32'h0);
		rd(5'h04, 32'h0000_77FF, 32'h0000_0101);
		rd(5'h08, 32'hFFFF_FFFF, 32'h0);
		rd(5'h1C, 32'hFFFF_FFFF, 32'h0);
		$display("test registers done");
		// masked sums on both outputs, last round saturates
		for (int i = 0; i < 12; i++)
		begin
			m = 4'hF >> (3 - i % 4);
			wr(5'h04, 32'h0000_1100 | {24'h0, m, m});
			feed(i == 11);
			chk(out_a, pair_exp(1, msum(m)));
			chk(out_b, pair_exp(1, msum(m)));
		end
		rd(5'h18, 32'h0000_0F03, 32'h0000_0003);
		$display("test sums done");
		// direct routing, then exchanged masks
		for (int i = 0; i < 2; i++)
		begin
			wr(5'h04, i ? 32'h0000_1112 : 32'h0000_1121);
			feed(1'b0);
			chk(out_a, pair_exp(1, 16'(v[i])));
			chk(out_b, pair_exp(1, 16'(v[1 - i])));
		end
		$display("test routing done");
		// every output A mode, B held in nrz
		for (int md = 0; md < 8; md++)
		begin
			wr(5'h04, 32'h0000_1033 | (32'(md) << 8));
			feed(1'b0);
			chk(out_a, pair_exp(md, msum(4'h3)));
			chk(out_b, pair_exp(1, msum(4'h3)));
		end
		rd(5'h04, 32'h0000_77FF, 32'h0000_1733);
		$display("test modes done");
		// take period for every interpolation code
		for (int c = 0; c < 16; c++)
		begin
			wr(5'h00, 32'(c));
			repeat (3) meas(n);
			chk(32'(n + 1), 32'(fac[c]));
		end
		$display("test factors done");
		wrap_up();
	end
endmodule : mdu_upconverter_top_tb
